// [mpl_link_regs.vh]
`ifndef MPL_LINK_REGS_VH
`define MPL_LINK_REGS_VH

// Clock and timing.
`define MPL_CLK_NS 10
`define MPL_RST_LOW_NS 1000
`define MPL_RST_LOW_CYC ((`MPL_RST_LOW_NS + `MPL_CLK_NS - 1) / `MPL_CLK_NS)
`define MPL_ANA_WIN_MS 40
`define MPL_ANA_WIN_CYC (`MPL_ANA_WIN_MS * 1000000 / `MPL_CLK_NS)
`define MPL_TRIG_WIN_US 300
`define MPL_TRIG_WIN_CYC (`MPL_TRIG_WIN_US * 1000 / `MPL_CLK_NS)
`define MPL_NV_WAIT_US 20
`define MPL_NV_WAIT_CYC (`MPL_NV_WAIT_US * 1000 / `MPL_CLK_NS)

// Frame layout.
`define MPL_RD_BITS 6'h0E
`define MPL_WR_BITS 6'h2E
`define MPL_TX_BITS 6'h25
`define MPL_CRC_POLY 3'h3
`define MPL_CRC_INIT 3'h0

// Chip select codes.
`define MPL_CS_BCAST0 2'h0
`define MPL_CS_DIE0 2'h1
`define MPL_CS_DIE1 2'h2
`define MPL_CS_BCAST1 2'h3

// Addresses and codes.
`define MPL_ACCESS_ADDR 8'h86
`define MPL_CTRL_ADDR 8'h87
`define MPL_NV_LIMIT 8'h40
`define MPL_UNLOCK_CODE 32'h414C5333
`define MPL_ACCESS_HI 31'h616C733D

// Output modes and access selection.
`define MPL_MODE_ANALOG 2'h0
`define MPL_SEL_LOCKED 2'h3

`endif

// [mpl_link.v]
`timescale 1ns/1ps
`include "mpl_link_regs.vh"

module mpl_link #(
   parameter integer ANA_WIN_CYC = `MPL_ANA_WIN_CYC,
   parameter integer TRIG_WIN_CYC = `MPL_TRIG_WIN_CYC,
   parameter integer NV_WAIT_CYC = `MPL_NV_WAIT_CYC
)(
   input wire core_clk_i,
   input wire srst_i,
   input wire line_i,
   output reg line_o,
   output reg line_oe_n_o,
   input wire overvoltage_detect_i,
   input wire trigger_i,
   input wire [1:0] out_mode_i,
   input wire [1:0] access_sel_i,
   input wire ana_lock_i,
   input wire die_addr_i,
   input wire dig_data_i,
   input wire drive_sel_i,
   input wire [2:0] push_lim_i,
   input wire push_lim_dis_i,
   input wire [31:0] rd_data_i,
   output reg [7:0] reg_addr_o,
   output reg [31:0] reg_wdata_o,
   output reg reg_wr_o,
   output reg nv_wr_o,
   output reg rd_req_o,
   output reg unlocked_o,
   output reg manch_en_o,
   output reg out_en_o,
   output reg push_pull_o,
   output reg [2:0] push_lim_o,
   output reg push_lim_dis_o
);

   localparam [1:0] D_IDLE = 2'h0;
   localparam [1:0] D_ARM = 2'h1;
   localparam [1:0] D_SYNC = 2'h2;
   localparam [1:0] D_BITS = 2'h3;
   localparam [2:0] P_IDLE = 3'h0;
   localparam [2:0] P_ACK = 3'h1;
   localparam [2:0] P_NVW = 3'h2;
   localparam [2:0] P_NVH = 3'h3;
   localparam [2:0] P_TX = 3'h4;
   localparam integer RST_LOW_CYC = `MPL_RST_LOW_CYC;
   localparam [15:0] RST_LOW = RST_LOW_CYC[15:0];
   localparam [22:0] ANA_WIN = ANA_WIN_CYC[22:0];
   localparam [15:0] TRIG_WIN = TRIG_WIN_CYC[15:0];
   localparam [22:0] NV_WAIT = NV_WAIT_CYC[22:0];

   function [2:0] crc_step;
      input [2:0] crc;
      input b;
      begin
         crc_step = {crc[1:0], 1'b0} ^
            ((crc[2] ^ b) ? `MPL_CRC_POLY : 3'h0);
      end
   endfunction

   function [2:0] crc_word;
      input [31:0] w;
      integer i;
      reg [2:0] c;
      begin
         c = `MPL_CRC_INIT;
         for (i = 31; i >= 0; i = i - 1)
            c = crc_step(c, w[i]);
         crc_word = c;
      end
   endfunction

   // Three stages per pin input: {trigger, overvoltage, line}.
   reg [2:0] s1_r;
   reg [2:0] s2_r;
   reg [2:0] s3_r;
   reg [2:0] flt_r;
   reg [2:0] prev_r;
   reg [1:0] dst_r;
   reg [15:0] cnt_r;
   reg [15:0] per_r;
   reg [5:0] nb_r;
   reg [45:0] sh_r;
   reg [2:0] crc_r;
   reg locked_r;
   reg unlock_seen_r;
   reg unlocked_r;
   reg manch_en_r;
   reg eval_r;
   reg ack_go_r;
   reg nv_go_r;
   reg [22:0] win_cnt_r;
   reg win_open_r;
   reg [15:0] trig_cnt_r;
   reg trig_win_r;
   reg [2:0] pst_r;
   reg [22:0] pcnt_r;
   reg half_r;
   reg [5:0] bi_r;
   reg [36:0] txsh_r;
   reg line_nxt;
   reg oe_n_nxt;

   wire line_w = flt_r[0];
   wire rise_w = flt_r[0] & ~prev_r[0];
   wire fall_w = ~flt_r[0] & prev_r[0];
   wire trig_ev_w = flt_r[2] & ~prev_r[2];
   wire analog_w = (out_mode_i == `MPL_MODE_ANALOG);
   wire ovd_ok_w = flt_r[1] & ~access_sel_i[1];
   wire trig_ok_w = trig_ev_w & ~access_sel_i[0];
   wire [16:0] q3_w = {1'b0, per_r} - {3'h0, per_r[15:2]};
   wire [16:0] q6_w = {1'b0, per_r} + {2'h0, per_r[15:1]};
   wire [15:0] hp_w = (per_r[15:1] == 15'h0) ? 16'h0001 : {1'b0, per_r[15:1]};
   wire rd_fr_w = (nb_r == `MPL_RD_BITS) & sh_r[13];
   wire wr_fr_w = (nb_r == `MPL_WR_BITS) & ~sh_r[45];
   wire [1:0] cs_w = rd_fr_w ? sh_r[12:11] : sh_r[44:43];
   wire [7:0] addr_w = rd_fr_w ? sh_r[10:3] : sh_r[42:35];
   wire [31:0] data_w = sh_r[34:3];
   wire cs_hit_w = (cs_w == `MPL_CS_BCAST0) | (cs_w == `MPL_CS_BCAST1) |
      ((cs_w == `MPL_CS_DIE0) & ~die_addr_i) |
      ((cs_w == `MPL_CS_DIE1) & die_addr_i);
   wire listen_w = (access_sel_i != `MPL_SEL_LOCKED) & ~locked_r &
      (analog_w ? (win_open_r | unlocked_r) :
      (ovd_ok_w | trig_win_r | manch_en_r));
   wire need_unlock_w = analog_w & ana_lock_i & ~unlock_seen_r;
   wire frame_ok_w = (crc_r == 3'h0) & cs_hit_w & listen_w &
      (rd_fr_w | wr_fr_w);
   wire is_access_w = wr_fr_w & (addr_w == `MPL_ACCESS_ADDR);
   wire is_unlock_w = is_access_w & (data_w == `MPL_UNLOCK_CODE);
   wire good_code_w = is_access_w & (data_w[31:1] == `MPL_ACCESS_HI);

   always @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         s1_r <= 3'h1;
         s2_r <= 3'h1;
         s3_r <= 3'h1;
         flt_r <= 3'h1;
         prev_r <= 3'h1;
      end
      else
      begin
         s1_r <= {trigger_i, overvoltage_detect_i, line_i};
         s2_r <= s1_r;
         s3_r <= s2_r;
         flt_r <= (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
         prev_r <= flt_r;
      end
   end

   // Decoder and command execution.
   always @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         dst_r <= D_IDLE;
         cnt_r <= 16'h0000;
         per_r <= 16'h0000;
         nb_r <= 6'h00;
         sh_r <= 46'h0;
         crc_r <= `MPL_CRC_INIT;
         locked_r <= 1'b0;
         unlock_seen_r <= 1'b0;
         unlocked_r <= 1'b0;
         manch_en_r <= 1'b0;
         eval_r <= 1'b0;
         ack_go_r <= 1'b0;
         nv_go_r <= 1'b0;
         reg_addr_o <= 8'h00;
         reg_wdata_o <= 32'h00000000;
         reg_wr_o <= 1'b0;
         nv_wr_o <= 1'b0;
         rd_req_o <= 1'b0;
      end
      else
      begin
         eval_r <= 1'b0;
         ack_go_r <= 1'b0;
         nv_go_r <= 1'b0;
         reg_wr_o <= 1'b0;
         nv_wr_o <= 1'b0;
         rd_req_o <= 1'b0;
         case (dst_r)
            D_IDLE:
            begin
               // A low run of the reset length arms the decoder.
               if (line_w)
                  cnt_r <= 16'h0000;
               else if (cnt_r >= RST_LOW - 16'h0001)
                  dst_r <= D_ARM;
               else
                  cnt_r <= cnt_r + 16'h0001;
            end
            D_ARM:
            begin
               cnt_r <= 16'h0000;
               if (rise_w)
                  dst_r <= D_SYNC;
            end
            D_SYNC:
            begin
               if (rise_w)
               begin
                  // The count restarts one cycle late, so add the edge cycle.
                  per_r <= cnt_r + 16'h0001;
                  cnt_r <= 16'h0000;
                  nb_r <= 6'h00;
                  crc_r <= `MPL_CRC_INIT;
                  dst_r <= D_BITS;
               end
               else if (cnt_r == 16'hFFFF)
               begin
                  cnt_r <= 16'h0000;
                  dst_r <= D_IDLE;
               end
               else
                  cnt_r <= cnt_r + 16'h0001;
            end
            D_BITS:
            begin
               // Edges before three quarters of a bit are boundary edges.
               if ((rise_w | fall_w) && ({1'b0, cnt_r} >= q3_w))
               begin
                  sh_r <= {sh_r[44:0], fall_w};
                  crc_r <= crc_step(crc_r, fall_w);
                  if (nb_r != 6'h3F)
                     nb_r <= nb_r + 6'h01;
                  cnt_r <= 16'h0000;
               end
               else if ({1'b0, cnt_r} > q6_w)
               begin
                  eval_r <= 1'b1;
                  cnt_r <= 16'h0000;
                  dst_r <= D_IDLE;
                  if (frame_ok_w)
                  begin
                     reg_addr_o <= addr_w;
                     reg_wdata_o <= data_w;
                     if (is_unlock_w)
                        unlock_seen_r <= 1'b1;
                     else if (need_unlock_w)
                        cnt_r <= 16'h0000;
                     else if (is_access_w)
                     begin
                        if (good_code_w)
                        begin
                           unlocked_r <= 1'b1;
                           manch_en_r <= data_w[0];
                           ack_go_r <= 1'b1;
                        end
                        else if (analog_w)
                           locked_r <= 1'b1;
                     end
                     else if (unlocked_r && rd_fr_w)
                        rd_req_o <= 1'b1;
                     else if (unlocked_r)
                     begin
                        if (addr_w == `MPL_CTRL_ADDR)
                        begin
                           manch_en_r <= data_w[0];
                           if (!data_w[0] && !analog_w)
                              unlocked_r <= 1'b0;
                        end
                        if (addr_w < `MPL_NV_LIMIT)
                        begin
                           nv_wr_o <= 1'b1;
                           nv_go_r <= 1'b1;
                        end
                        else
                        begin
                           reg_wr_o <= 1'b1;
                           ack_go_r <= 1'b1;
                        end
                     end
                  end
               end
               else
                  cnt_r <= cnt_r + 16'h0001;
            end
            default:
               dst_r <= D_IDLE;
         endcase
         // Our own drive on the line must not be decoded as a command.
         if (pst_r != P_IDLE)
         begin
            dst_r <= D_IDLE;
            cnt_r <= 16'h0000;
         end
      end
   end

   // Analog listen window after reset and the trigger entry window.
   always @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         win_cnt_r <= 23'h000000;
         win_open_r <= 1'b1;
         trig_cnt_r <= 16'h0000;
         trig_win_r <= 1'b0;
      end
      else
      begin
         if (win_open_r && dst_r != D_BITS)
         begin
            if (win_cnt_r >= ANA_WIN - 23'h000001)
               win_open_r <= 1'b0;
            else
               win_cnt_r <= win_cnt_r + 23'h000001;
         end
         if (trig_ok_w && !analog_w)
         begin
            trig_win_r <= 1'b1;
            trig_cnt_r <= 16'h0000;
         end
         else if (eval_r)
            trig_win_r <= 1'b0;
         else if (trig_win_r && dst_r != D_BITS)
         begin
            if (trig_cnt_r >= TRIG_WIN - 16'h0001)
               trig_win_r <= 1'b0;
            else
               trig_cnt_r <= trig_cnt_r + 16'h0001;
         end
      end
   end

   // Pin engine: acknowledge, store-done edge and read answer.
   always @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         pst_r <= P_IDLE;
         pcnt_r <= 23'h000000;
         half_r <= 1'b0;
         bi_r <= 6'h00;
         txsh_r <= 37'h0;
      end
      else
      begin
         case (pst_r)
            P_IDLE:
            begin
               pcnt_r <= 23'h000000;
               half_r <= 1'b0;
               bi_r <= 6'h00;
               if (ack_go_r)
                  pst_r <= P_ACK;
               else if (nv_go_r)
                  pst_r <= P_NVW;
               else if (rd_req_o)
               begin
                  txsh_r <= {2'b00, rd_data_i, crc_word(rd_data_i)};
                  pst_r <= P_TX;
               end
            end
            P_ACK:
            begin
               if (pcnt_r >= {7'h00, per_r})
                  pst_r <= P_IDLE;
               else
                  pcnt_r <= pcnt_r + 23'h000001;
            end
            P_NVW:
            begin
               if (pcnt_r >= NV_WAIT - 23'h000001)
               begin
                  pcnt_r <= 23'h000000;
                  pst_r <= P_NVH;
               end
               else
                  pcnt_r <= pcnt_r + 23'h000001;
            end
            P_NVH:
            begin
               if (pcnt_r >= {7'h00, per_r})
                  pst_r <= P_IDLE;
               else
                  pcnt_r <= pcnt_r + 23'h000001;
            end
            P_TX:
            begin
               if (pcnt_r >= {7'h00, hp_w} - 23'h000001)
               begin
                  pcnt_r <= 23'h000000;
                  half_r <= ~half_r;
                  if (half_r)
                  begin
                     txsh_r <= {txsh_r[35:0], 1'b0};
                     bi_r <= bi_r + 6'h01;
                     if (bi_r == `MPL_TX_BITS - 6'h01)
                        pst_r <= P_IDLE;
                  end
               end
               else
                  pcnt_r <= pcnt_r + 23'h000001;
            end
            default:
               pst_r <= P_IDLE;
         endcase
      end
   end

   always @*
   begin
      line_nxt = 1'b0;
      oe_n_nxt = 1'b1;
      case (pst_r)
         P_ACK, P_NVW:
            oe_n_nxt = 1'b0;
         P_NVH:
         begin
            oe_n_nxt = 1'b0;
            line_nxt = 1'b1;
         end
         P_TX:
         begin
            oe_n_nxt = 1'b0;
            line_nxt = half_r ? ~txsh_r[36] : txsh_r[36];
         end
         default:
         begin
            if (!analog_w && !ovd_ok_w && !manch_en_r && !trig_win_r)
            begin
               if (!drive_sel_i)
               begin
                  oe_n_nxt = 1'b0;
                  line_nxt = dig_data_i;
               end
               else
                  oe_n_nxt = dig_data_i;
            end
         end
      endcase
   end

   always @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         line_o <= 1'b0;
         line_oe_n_o <= 1'b1;
         unlocked_o <= 1'b0;
         manch_en_o <= 1'b0;
         out_en_o <= 1'b1;
         push_pull_o <= 1'b0;
         push_lim_o <= 3'h0;
         push_lim_dis_o <= 1'b0;
      end
      else
      begin
         line_o <= line_nxt;
         line_oe_n_o <= oe_n_nxt;
         unlocked_o <= unlocked_r;
         manch_en_o <= manch_en_r;
         out_en_o <= analog_w ? ~(unlocked_r & manch_en_r) :
            ~(ovd_ok_w | manch_en_r | trig_win_r);
         push_pull_o <= ~drive_sel_i;
         push_lim_o <= push_lim_i;
         push_lim_dis_o <= push_lim_dis_i;
      end
   end

endmodule

// [mpl_link_assertions.sv]
`timescale 1ns/1ps
module mpl_link_assertions (
   input wire core_clk_i,
   input wire srst_i,
   input wire overvoltage_detect_i,
   input wire [1:0] out_mode_i,
   input wire [1:0] access_sel_i,
   input wire drive_sel_i,
   input wire line_o,
   input wire line_oe_n_o,
   input wire [7:0] reg_addr_o,
   input wire [31:0] reg_wdata_o,
   input wire reg_wr_o,
   input wire nv_wr_o,
   input wire rd_req_o,
   input wire unlocked_o,
   input wire out_en_o,
   input wire push_pull_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);
   reg [2:0] req_hist_r;
   // Replies start a few cycles after the decode pulse, so a short pulse
   // history is kept to tie each reply on the pin to its cause. An
   // accepted access code is acknowledged without a pulse, so the rise of
   // the unlock flag counts as a cause for the code that sets it.
   always @(posedge core_clk_i)
   begin
      if (srst_i)
         req_hist_r <= 3'h0;
      else
         req_hist_r <= {req_hist_r[1:0], reg_wr_o | nv_wr_o | rd_req_o |
            $rose(unlocked_o)};
   end
   property p_wr_pulse;
      reg_wr_o |=> !reg_wr_o;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write pulse longer than one cycle");
   property p_ack;
      reg_wr_o |-> ##[1:4] (!line_oe_n_o && !line_o);
   endproperty
   a_ack: assert property (p_ack)
      else $error("no low acknowledge after a write");
   property p_no_start;
      $fell(line_oe_n_o) && !out_en_o && !$past(out_en_o)
         |-> req_hist_r != 3'h0;
   endproperty
   a_no_start: assert property (p_no_start)
      else $error("pin driven without a host frame");
   property p_ov_off;
      (overvoltage_detect_i && out_mode_i != 2'h0 && !access_sel_i[1])[*8]
         |-> !out_en_o;
   endproperty
   a_ov_off: assert property (p_ov_off)
      else $error("digital output still on under overvoltage");
   property p_push;
      $stable(drive_sel_i) |=> push_pull_o == !$past(drive_sel_i);
   endproperty
   a_push: assert property (p_push)
      else $error("push-pull select does not follow drive select");
   property p_nv_ack;
      nv_wr_o |-> ##[1:4] (!line_oe_n_o && !line_o)[*8];
   endproperty
   a_nv_ack: assert property (p_nv_ack)
      else $error("store wait not held low");
   property p_relock;
      $fell(unlocked_o) |-> ##[0:2] (reg_addr_o == 8'h87 && !reg_wdata_o[0]);
   endproperty
   a_relock: assert property (p_relock)
      else $error("relock without clearing the disable flag");
   property p_rd_start;
      rd_req_o |-> ##[1:4] (!line_oe_n_o && !line_o);
   endproperty
   a_rd_start: assert property (p_rd_start)
      else $error("read answer does not start with a low sync half");
endmodule

// [mpl_host_model.sv]
`timescale 1ns/1ps
module mpl_host_model (
   input wire core_clk_i,
   input wire line_i,
   output reg host_oe_o,
   output reg host_val_o
);
   initial
   begin
      host_oe_o = 1'b0;
      host_val_o = 1'b1;
   end
   // Both ends send a bit as its first-half level, then the inverse.
   task half(input v, input integer n);
      integer j;
      begin
         host_val_o <= v;
         for (j = 0; j < n; j = j + 1)
            @(posedge core_clk_i);
      end
   endtask
   task send(input [45:0] b, input integer n, input integer hp);
      integer i;
      begin
         @(posedge core_clk_i);
         host_oe_o <= 1'b1;
         half(1'b0, 150);
         for (i = 0; i < 2; i = i + 1)
         begin
            half(1'b0, hp);
            half(1'b1, hp);
         end
         for (i = n - 1; i >= 0; i = i - 1)
         begin
            half(b[i], hp);
            half(!b[i], hp);
         end
         // Released line falls back to the pull-up level.
         host_oe_o <= 1'b0;
      end
   endtask
   // Samples mid first half; the caller waits for the end before sending.
   task recv(input integer hp, output [36:0] bits, output ok);
      integer i;
      begin
         ok = 1'b0;
         for (i = 0; i < 3000 && !ok; i = i + 1)
         begin
            @(negedge core_clk_i);
            ok = (line_i === 1'b0);
         end
         repeat (hp / 2) @(negedge core_clk_i);
         for (i = 36; i >= 0; i = i - 1)
         begin
            bits[i] = line_i;
            repeat (2 * hp) @(negedge core_clk_i);
         end
      end
   endtask
endmodule

// [test_mpl_link.sv]
`timescale 1ns/1ps
`include "mpl_link_regs.vh"
`define CHK(n, e, g) begin compares = compares + 1; \
   if ((g) !== (e)) begin failures = failures + 1; \
   $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module test_mpl_link;
   localparam integer NV = 50;
   reg core_clk_i, srst_i, overvoltage_detect_i, trigger_i, ana_lock_i;
   reg die_addr_i, dig_data_i, drive_sel_i, push_lim_dis_i;
   reg [1:0] out_mode_i, access_sel_i;
   reg [2:0] push_lim_i;
   reg [31:0] rd_data_i, seed;
   wire line_o, line_oe_n_o, reg_wr_o, nv_wr_o, rd_req_o, unlocked_o;
   wire manch_en_o, out_en_o, push_pull_o, push_lim_dis_o, host_oe, host_val;
   wire [7:0] reg_addr_o;
   wire [31:0] reg_wdata_o;
   wire [2:0] push_lim_o;
   wire line_w = !line_oe_n_o ? line_o : (host_oe ? host_val : 1'b1);
   integer failures, compares, n_wr, n_nv, n_rd, k, c0, lowc;
   reg [36:0] ans;
   reg ok;
   mpl_link #(.ANA_WIN_CYC(2000), .TRIG_WIN_CYC(500), .NV_WAIT_CYC(NV)) i_dut (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .line_i(line_w),
      .line_o(line_o), .line_oe_n_o(line_oe_n_o),
      .overvoltage_detect_i(overvoltage_detect_i), .trigger_i(trigger_i),
      .out_mode_i(out_mode_i), .access_sel_i(access_sel_i),
      .ana_lock_i(ana_lock_i), .die_addr_i(die_addr_i),
      .dig_data_i(dig_data_i), .drive_sel_i(drive_sel_i),
      .push_lim_i(push_lim_i), .push_lim_dis_i(push_lim_dis_i),
      .rd_data_i(rd_data_i), .reg_addr_o(reg_addr_o),
      .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o), .nv_wr_o(nv_wr_o),
      .rd_req_o(rd_req_o), .unlocked_o(unlocked_o), .manch_en_o(manch_en_o),
      .out_en_o(out_en_o), .push_pull_o(push_pull_o),
      .push_lim_o(push_lim_o), .push_lim_dis_o(push_lim_dis_o));
   mpl_host_model i_host (.core_clk_i(core_clk_i), .line_i(line_w),
      .host_oe_o(host_oe), .host_val_o(host_val));
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function [2:0] crc3(input [42:0] v, input integer n);
      integer i;
      begin
         crc3 = 3'h0;
         for (i = n - 1; i >= 0; i = i - 1)
            crc3 = {crc3[1:0], 1'b0} ^ ((crc3[2] ^ v[i]) ? 3'h3 : 3'h0);
      end
   endfunction
   task final_report;
      begin
         $display("compares %0d failures %0d", compares, failures);
         if (failures == 0 && compares > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task xfer(input rw, input [1:0] cs, input [7:0] a, input [31:0] dd,
      input bad, input integer hp);
      reg [42:0] p;
      begin
         p = rw ? {32'h0, rw, cs, a} : {rw, cs, a, dd};
         if (rw)
            i_host.send({32'h0, p[10:0], crc3(p, 11)}, 14, hp);
         else
            i_host.send({p, crc3(p, 43)} ^ {45'h0, bad}, 46, hp);
      end
   endtask
   // Long enough for decode, acknowledge and the idle the next frame needs.
   task gap;
      repeat (400) @(negedge core_clk_i);
   endtask
   task wr(input [1:0] cs, input [7:0] a, input [31:0] dd, input bad,
      input e);
      begin
         c0 = n_wr;
         xfer(1'b0, cs, a, dd, bad, 8);
         gap;
         `CHK("write pulse", e, n_wr - c0 == 1)
         if (e)
            `CHK("write fields", {a, dd}, {reg_addr_o, reg_wdata_o})
      end
   endtask
   task acc(input lsb, input e);
      begin
         xfer(1'b0, 2'h0, `MPL_ACCESS_ADDR, {`MPL_ACCESS_HI, lsb}, 1'b0, 8);
         gap;
         `CHK("unlocked", {e, e & lsb}, {unlocked_o, manch_en_o})
      end
   endtask
   task rd(input [7:0] a, input integer hp);
      begin
         seed = lfsr(seed);
         @(posedge core_clk_i);
         rd_data_i <= seed;
         c0 = n_rd;
         xfer(1'b1, 2'h0, a, 32'h0, 1'b0, hp);
         i_host.recv(hp, ans, ok);
         if (!ok)
         begin
            failures = failures + 1;
            final_report;
         end
         `CHK("read pulse", 1'b1, n_rd - c0 == 1)
         `CHK("read frame", {2'h0, seed, crc3({11'h0, seed}, 32)}, ans)
         gap;
      end
   endtask
   always @(posedge core_clk_i)
   begin
      n_wr = n_wr + (reg_wr_o === 1'b1);
      n_nv = n_nv + (nv_wr_o === 1'b1);
      n_rd = n_rd + (rd_req_o === 1'b1);
   end
   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   initial
   begin
      {failures, compares, n_wr, n_nv, n_rd} = 0;
      seed = 32'hF92D;
      srst_i = 1'b1;
      overvoltage_detect_i = 1'b1;
      {trigger_i, ana_lock_i, die_addr_i, push_lim_dis_i} = 4'h0;
      {dig_data_i, drive_sel_i} = 2'h3;
      out_mode_i = 2'h1;
      access_sel_i = 2'h0;
      push_lim_i = 3'h0;
      rd_data_i = 32'h0;
      repeat (5) @(posedge core_clk_i);
      srst_i <= 1'b0;
      repeat (200) @(negedge core_clk_i);
      wr(2'h0, 8'h50, seed, 1'b0, 1'b0);
      acc(1'b1, 1'b1);
      for (k = 0; k < 4; k = k + 1)
      begin
         seed = lfsr(seed);
         wr(k[1:0], 8'h50 + k[7:0], seed, 1'b0, k != 2);
      end
      wr(2'h0, 8'h51, seed, 1'b1, 1'b0);
      rd(8'h60, 8);
      rd(8'h7F, 13);
      @(posedge core_clk_i);
      overvoltage_detect_i <= 1'b0;
      c0 = n_nv;
      lowc = 0;
      xfer(1'b0, 2'h0, 8'h10, seed, 1'b0, 8);
      for (k = 0; k < 3000 && !(!line_oe_n_o && line_o); k = k + 1)
      begin
         @(negedge core_clk_i);
         lowc = lowc + (!line_oe_n_o && !line_o);
      end
      if (k == 3000)
      begin
         failures = failures + 1;
         final_report;
      end
      `CHK("store pulse", 1'b1, n_nv - c0 == 1)
      `CHK("store wait", 1'b1, lowc >= NV)
      gap;
      wr(2'h0, 8'h87, 32'h0, 1'b0, 1'b1);
      `CHK("relocked", 1'b0, unlocked_o)
      @(posedge core_clk_i);
      overvoltage_detect_i <= 1'b1;
      for (k = 3; k > 0; k = k - 1)
      begin
         @(posedge core_clk_i);
         access_sel_i <= k[1:0];
         acc(1'b0, k == 1);
      end
      for (k = 0; k < 4; k = k + 1)
      begin
         seed = lfsr(seed);
         @(posedge core_clk_i);
         {push_lim_dis_i, push_lim_i, drive_sel_i, dig_data_i} <= seed[5:0];
         repeat (3) @(negedge core_clk_i);
         `CHK("drive", {~seed[1], seed[5:2]},
            {push_pull_o, push_lim_dis_o, push_lim_o})
      end
      @(posedge core_clk_i);
      {overvoltage_detect_i, drive_sel_i, dig_data_i} <= 3'h3;
      repeat (20) @(negedge core_clk_i);
      `CHK("output back", 1'b1, out_en_o)
      wr(2'h0, 8'h52, seed, 1'b0, 1'b0);
      // Analog mode with the lock bit set: the unlock code must come first.
      @(posedge core_clk_i);
      {srst_i, out_mode_i, ana_lock_i} <= 4'h9;
      repeat (5) @(posedge core_clk_i);
      srst_i <= 1'b0;
      repeat (200) @(negedge core_clk_i);
      acc(1'b1, 1'b0);
      wr(2'h0, `MPL_ACCESS_ADDR, `MPL_UNLOCK_CODE, 1'b0, 1'b0);
      acc(1'b1, 1'b1);
      `CHK("analog off", 1'b0, out_en_o)
      final_report;
   end
endmodule
bind mpl_link mpl_link_assertions i_chk (.core_clk_i(core_clk_i),
   .srst_i(srst_i), .overvoltage_detect_i(overvoltage_detect_i),
   .out_mode_i(out_mode_i), .access_sel_i(access_sel_i),
   .drive_sel_i(drive_sel_i), .line_o(line_o), .line_oe_n_o(line_oe_n_o),
   .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o),
   .nv_wr_o(nv_wr_o), .rd_req_o(rd_req_o), .unlocked_o(unlocked_o),
   .out_en_o(out_en_o), .push_pull_o(push_pull_o));
